/* File: pkg/bccf_pkg.sv */
package bccf_pkg;
    localparam logic [11:0] ADDR_CHIP_CONTROL_ZERO = 12'h040;
    localparam logic [11:0] ADDR_READ_REQUEST_CONTROL = 12'h03C;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h050;
    localparam logic [11:0] ADDR_INT_MASK = 12'h054;
    localparam int BIT_MALFORMED = 11;
    localparam int BIT_MRBC_LO = 12;
    localparam int BIT_FC_UPDATE = 15;
    localparam int BIT_RETRY_STATUS = 16;
    localparam int BIT_RETRY_LIM_LO = 17;
    localparam int BIT_DISCARD_DIS = 19;
    localparam int BIT_SHORT_DUR = 20;
    localparam int BIT_CRS_LO = 21;
    localparam int BIT_DT_ORDER = 23;
    localparam int BIT_BC_FWD_TIMER = 24;
    localparam int BIT_BC_REV_TIMER = 25;
    localparam int BIT_BC_DISCARD_EN = 27;
    localparam logic [31:0] CC0_WRITE_MASK = 32'h00FEF800;
    localparam logic [31:0] CC0_RESET = 32'h00200000;
    localparam logic [31:0] RRC_WRITE_MASK = 32'h0B000000;
    localparam logic [31:0] RRC_RESET = 32'h00000000;
    localparam logic [1:0] INT_WRITE_MASK = 2'h3;
    localparam logic [2:0] MRBC_128 = 3'h1;
    localparam logic [2:0] MRBC_256 = 3'h2;
    localparam logic [2:0] MRBC_1024 = 3'h4;
    localparam logic [2:0] MRBC_2048 = 3'h5;
    localparam logic [2:0] MRBC_4096 = 3'h6;
    localparam logic [12:0] BYTES_128 = 13'h0080;
    localparam logic [12:0] BYTES_256 = 13'h0100;
    localparam logic [12:0] BYTES_512 = 13'h0200;
    localparam logic [12:0] BYTES_1024 = 13'h0400;
    localparam logic [12:0] BYTES_2048 = 13'h0800;
    localparam logic [12:0] BYTES_4096 = 13'h1000;
    localparam logic [31:0] RETRY_LIM_256 = 32'h00000100;
    localparam logic [31:0] RETRY_LIM_64K = 32'h00010000;
    localparam logic [31:0] RETRY_LIM_2G = 32'h80000000;
    localparam logic [7:0] DISCARD_SHORT = 8'h40;
    localparam logic [31:0] DISCARD_SEL_CLOCKS = 32'h00000400;
    localparam logic [31:0] DISCARD_DEF_CLOCKS = 32'h00008000;
    localparam int CLK_HZ = 25000000;
    localparam int CRS_US_00 = 25;
    localparam int CRS_US_01 = 500;
    localparam int CRS_US_10 = 5000;
    localparam int CRS_US_11 = 25000;
    localparam logic [1:0] FC_STEP_TWO = 2'h2;
    localparam logic [1:0] FC_STEP_ONE = 2'h1;
    typedef enum logic [1:0] {
        BCCF_IDLE = 2'b00,
        BCCF_SETUP = 2'b01,
        BCCF_ACCESS = 2'b11
    } bccf_apb_state_type;
endpackage : bccf_pkg

/* File: src/bccf_timer.sv */
`timescale 1ns/10ps
// Up counter: counts enabled ticks while run is high, holds expired once the limit is met
module bccf_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic tick,
    input wire logic [31:0] limit,
    output logic expired
);
    logic [31:0] count;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 32'h0;
            expired <= 1'b0;
        end else if (!run) begin
            count <= 32'h0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            if (count + 32'h1 >= limit) begin
                expired <= 1'b1;
            end
            count <= count + 32'h1;
        end
    end
endmodule : bccf_timer

/* File: src/bccf_control.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module bccf_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic reverse_mode,
    input wire logic pci_clk_tick,
    input wire logic malformed_seen,
    output logic malformed_error,
    input wire logic full_prefetch,
    output logic [12:0] read_request_bytes,
    input wire logic credit_freed,
    output logic credit_update,
    input wire logic retry_seen,
    input wire logic transaction_done,
    input wire logic discard_start,
    output logic discard_expired,
    input wire logic cfg_retry_start,
    output logic cfg_retry_expired,
    output logic in_order_only
);
    import bccf_pkg::*;

    logic [31:0] chip_control_zero;
    logic [31:0] read_request_control;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic wr_en;
    logic retry_expired_pulse;
    logic retry_expired_lvl;
    logic retry_expired_d;
    logic [1:0] credit_count;
    logic [31:0] retry_limit;
    logic discard_run;
    logic [31:0] discard_limit;
    logic cfg_run;
    logic [31:0] cfg_limit;
    logic discard_lvl;
    logic cfg_lvl;
    logic cfg_d;
    logic cfg_pulse;

    function automatic logic [12:0] mrbc_decode(input logic [2:0] code);
        case (code)
            MRBC_128: mrbc_decode = BYTES_128;
            MRBC_256: mrbc_decode = BYTES_256;
            MRBC_1024: mrbc_decode = BYTES_1024;
            MRBC_2048: mrbc_decode = BYTES_2048;
            MRBC_4096: mrbc_decode = BYTES_4096;
            default: mrbc_decode = BYTES_512;
        endcase
    endfunction : mrbc_decode

    function automatic logic [31:0] us_to_cycles(input int us);
        us_to_cycles = 32'(us * (CLK_HZ / 1000000));
    endfunction : us_to_cycles

    // APB: zero wait states, every access completes in its access phase
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_control_zero <= CC0_RESET;
        end else begin
            if (wr_en && paddr == ADDR_CHIP_CONTROL_ZERO) begin
                chip_control_zero <= (pwdata & CC0_WRITE_MASK)
                    | (chip_control_zero & ~CC0_WRITE_MASK);
            end
            // Status bit: set wins over a write-one clear in the same cycle
            if (retry_expired_pulse) begin
                chip_control_zero[BIT_RETRY_STATUS] <= 1'b1;
            end else if (wr_en && paddr == ADDR_CHIP_CONTROL_ZERO
                && pwdata[BIT_RETRY_STATUS]) begin
                chip_control_zero[BIT_RETRY_STATUS] <= 1'b0;
            end else begin
                chip_control_zero[BIT_RETRY_STATUS] <= chip_control_zero[BIT_RETRY_STATUS];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_request_control <= RRC_RESET;
        end else if (wr_en && paddr == ADDR_READ_REQUEST_CONTROL) begin
            read_request_control <= pwdata & RRC_WRITE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 2'h0;
            int_mask <= 2'h0;
        end else begin
            if (wr_en && paddr == ADDR_INT_MASK) begin
                int_mask <= pwdata[1:0] & INT_WRITE_MASK;
            end
            int_status[0] <= retry_expired_pulse
                | (int_status[0] & ~(wr_en && paddr == ADDR_INT_STATUS && pwdata[0]));
            int_status[1] <= cfg_pulse
                | (int_status[1] & ~(wr_en && paddr == ADDR_INT_STATUS && pwdata[1]));
        end
    end

    assign irq = |(int_status & int_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CHIP_CONTROL_ZERO: prdata <= chip_control_zero;
                ADDR_READ_REQUEST_CONTROL: prdata <= read_request_control;
                ADDR_INT_STATUS: prdata <= {30'h0, int_status};
                ADDR_INT_MASK: prdata <= {30'h0, int_mask};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Checks run only while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            malformed_error <= 1'b0;
        end else begin
            malformed_error <= malformed_seen && chip_control_zero[BIT_MALFORMED];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_request_bytes <= BYTES_512;
        end else if (full_prefetch) begin
            read_request_bytes <= mrbc_decode(chip_control_zero[BIT_MRBC_LO +: 3]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            credit_count <= 2'h0;
            credit_update <= 1'b0;
        end else begin
            credit_update <= 1'b0;
            if (credit_freed) begin
                if (chip_control_zero[BIT_FC_UPDATE] || credit_count + 2'h1 >= FC_STEP_TWO) begin
                    credit_update <= 1'b1;
                    credit_count <= 2'h0;
                end else begin
                    credit_count <= credit_count + 2'h1;
                end
            end
        end
    end

    always_comb begin
        case (chip_control_zero[BIT_RETRY_LIM_LO +: 2])
            2'h1: retry_limit = RETRY_LIM_256;
            2'h2: retry_limit = RETRY_LIM_64K;
            2'h3: retry_limit = RETRY_LIM_2G;
            default: retry_limit = 32'h0;
        endcase
    end

    // Unlimited mode keeps the counter idle so it never expires
    bccf_timer u_retry (
        .pclk(pclk),
        .presetn(presetn),
        .run(!transaction_done && retry_limit != 32'h0),
        .tick(retry_seen),
        .limit(retry_limit),
        .expired(retry_expired_lvl)
    );

    always_comb begin
        if (chip_control_zero[BIT_SHORT_DUR]) begin
            discard_limit = {24'h0, DISCARD_SHORT};
        end else if (reverse_mode) begin
            discard_limit = read_request_control[BIT_BC_REV_TIMER]
                ? DISCARD_SEL_CLOCKS : DISCARD_DEF_CLOCKS;
        end else begin
            discard_limit = read_request_control[BIT_BC_FWD_TIMER]
                ? DISCARD_SEL_CLOCKS : DISCARD_DEF_CLOCKS;
        end
    end

    assign discard_run = discard_start && !chip_control_zero[BIT_DISCARD_DIS]
        && read_request_control[BIT_BC_DISCARD_EN];

    bccf_timer u_discard (
        .pclk(pclk),
        .presetn(presetn),
        .run(discard_run),
        .tick(pci_clk_tick),
        .limit(discard_limit),
        .expired(discard_lvl)
    );

    always_comb begin
        case (chip_control_zero[BIT_CRS_LO +: 2])
            2'h0: cfg_limit = us_to_cycles(CRS_US_00);
            2'h1: cfg_limit = us_to_cycles(CRS_US_01);
            2'h2: cfg_limit = us_to_cycles(CRS_US_10);
            default: cfg_limit = us_to_cycles(CRS_US_11);
        endcase
    end

    assign cfg_run = cfg_retry_start;

    bccf_timer u_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .run(cfg_run),
        .tick(1'b1),
        .limit(cfg_limit),
        .expired(cfg_lvl)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_expired_d <= 1'b0;
            cfg_d <= 1'b0;
        end else begin
            retry_expired_d <= retry_expired_lvl;
            cfg_d <= cfg_lvl;
        end
    end

    assign retry_expired_pulse = retry_expired_lvl && !retry_expired_d;
    assign cfg_pulse = cfg_lvl && !cfg_d;
    assign discard_expired = discard_lvl;
    assign cfg_retry_expired = cfg_lvl;
    assign in_order_only = chip_control_zero[BIT_DT_ORDER];

    a_malformed_gate: assert property (@(posedge pclk) disable iff (!presetn)
        malformed_error
        |-> $past(chip_control_zero[BIT_MALFORMED]))
        else $error("malformed error while checks off");
    a_malformed_pass: assert property (@(posedge pclk) disable iff (!presetn)
        malformed_seen && chip_control_zero[BIT_MALFORMED]
        |=> malformed_error)
        else $error("malformed packet not flagged");
    a_prefetch_size: assert property (@(posedge pclk) disable iff (!presetn)
        full_prefetch && chip_control_zero[BIT_MRBC_LO +: 3] == MRBC_4096
        |=> read_request_bytes == BYTES_4096)
        else $error("prefetch size wrong");
    a_size_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !full_prefetch
        |=> $stable(read_request_bytes))
        else $error("byte count moved without prefetch");
    a_default_size: assert property (@(posedge pclk) disable iff (!presetn)
        full_prefetch && chip_control_zero[BIT_MRBC_LO +: 3] == 3'h7
        |=> read_request_bytes == BYTES_512)
        else $error("code 7 not 512 bytes");
    a_size_small: assert property (@(posedge pclk) disable iff (!presetn)
        full_prefetch && chip_control_zero[BIT_MRBC_LO +: 3] == MRBC_128
        |=> read_request_bytes == BYTES_128)
        else $error("code 1 not 128 bytes");
    a_size_zero: assert property (@(posedge pclk) disable iff (!presetn)
        full_prefetch && chip_control_zero[BIT_MRBC_LO +: 3] == 3'h0
        |=> read_request_bytes == BYTES_512)
        else $error("code 0 not 512 bytes");
    a_credit_one: assert property (@(posedge pclk) disable iff (!presetn)
        credit_freed && chip_control_zero[BIT_FC_UPDATE]
        |=> credit_update)
        else $error("single credit update missing");
    a_credit_two: assert property (@(posedge pclk) disable iff (!presetn)
        credit_freed && !chip_control_zero[BIT_FC_UPDATE] && credit_count == 2'h1
        |=> credit_update)
        else $error("second credit update missing");
    a_credit_half: assert property (@(posedge pclk) disable iff (!presetn)
        credit_freed && !chip_control_zero[BIT_FC_UPDATE] && credit_count == 2'h0
        |=> !credit_update)
        else $error("update after one credit in pairs mode");
    a_credit_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !credit_freed
        |=> !credit_update)
        else $error("credit update without freed credit");
    a_retry_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        retry_expired_pulse
        |=> chip_control_zero[BIT_RETRY_STATUS])
        else $error("retry status not set");
    a_retry_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ADDR_CHIP_CONTROL_ZERO && pwdata[BIT_RETRY_STATUS]
        && !retry_expired_pulse
        |=> !chip_control_zero[BIT_RETRY_STATUS])
        else $error("retry status not cleared");
    a_retry_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !retry_expired_pulse && !(wr_en && paddr == ADDR_CHIP_CONTROL_ZERO)
        |=> $stable(chip_control_zero[BIT_RETRY_STATUS]))
        else $error("retry status changed on its own");
    a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        retry_expired_pulse && int_mask[0] && !(wr_en && paddr == ADDR_INT_MASK)
        |=> irq)
        else $error("unmasked retry expiry gave no interrupt");
    a_no_limit: assert property (@(posedge pclk) disable iff (!presetn)
        chip_control_zero[BIT_RETRY_LIM_LO +: 2] == 2'h0
        |=> !retry_expired_lvl)
        else $error("expiry with no limit");
    a_retry_count: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(retry_expired_lvl) && retry_limit == RETRY_LIM_256
        |-> u_retry.count == RETRY_LIM_256)
        else $error("retry expiry not at 256");
    a_discard_off: assert property (@(posedge pclk) disable iff (!presetn)
        chip_control_zero[BIT_DISCARD_DIS]
        |=> !discard_lvl)
        else $error("discard timer ran while disabled");
    a_short_expiry: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(discard_lvl) && chip_control_zero[BIT_SHORT_DUR]
        |-> u_discard.count == {24'h0, DISCARD_SHORT})
        else $error("short discard expiry not at 64 clocks");
    a_discard_sel: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(discard_lvl) && !chip_control_zero[BIT_SHORT_DUR] && !reverse_mode
        && read_request_control[BIT_BC_FWD_TIMER]
        |-> u_discard.count == DISCARD_SEL_CLOCKS)
        else $error("forward discard timeout wrong");
    a_cfg_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn)
        |-> chip_control_zero[BIT_CRS_LO +: 2] == 2'h1)
        else $error("config retry code not 01");
    a_cfg_short: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg_lvl) && chip_control_zero[BIT_CRS_LO +: 2] == 2'h0
        |-> u_cfg.count == us_to_cycles(CRS_US_00))
        else $error("config retry timer not at 25us");
    a_order_follow: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ADDR_CHIP_CONTROL_ZERO
        |=> in_order_only == $past(pwdata[BIT_DT_ORDER]))
        else $error("order control mismatch");
endmodule : bccf_control

/* File: verification/bridge_chip_control_fields_test.sv */
`timescale 1ns/10ps
module bridge_chip_control_fields_test;
    import bccf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic reverse_mode, pci_clk_tick, malformed_seen, malformed_error, full_prefetch;
    logic [12:0] read_request_bytes, exp_b;
    logic credit_freed, credit_update, retry_seen, transaction_done, discard_start;
    logic discard_expired, cfg_retry_start, cfg_retry_expired, in_order_only;
    int n_fail, tests_run, n_cu, n_mal, n, c;

    bccf_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .reverse_mode(reverse_mode), .pci_clk_tick(pci_clk_tick),
        .malformed_seen(malformed_seen), .malformed_error(malformed_error),
        .full_prefetch(full_prefetch), .read_request_bytes(read_request_bytes),
        .credit_freed(credit_freed), .credit_update(credit_update), .retry_seen(retry_seen),
        .transaction_done(transaction_done), .discard_start(discard_start),
        .discard_expired(discard_expired), .cfg_retry_start(cfg_retry_start),
        .cfg_retry_expired(cfg_retry_expired), .in_order_only(in_order_only));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Pulse outputs are counted here so no single cycle can be missed
    always @(posedge pclk) begin
        if (credit_update === 1'b1) n_cu++;
        if (malformed_error === 1'b1) n_mal++;
    end

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude

    // One idle cycle after each transfer keeps psel from being driven twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            n_fail++;
            conclude();
        end
        @(posedge pclk);
    endtask : apb

    task wait_hi(input int sel, input int lim);
        for (c = 0; c < lim; c++) begin
            @(posedge pclk);
            if ((sel == 0 ? discard_expired : cfg_retry_expired) === 1'b1) break;
        end
    endtask : wait_hi

    task retries(input int k);
        repeat (k) begin
            retry_seen <= 1'b1;
            @(posedge pclk);
            retry_seen <= 1'b0;
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask : retries

    task t_reset;
        apb(1'b0, ADDR_CHIP_CONTROL_ZERO, 32'h0);
        chk("cc0 reset", rd, CC0_RESET);
        apb(1'b0, ADDR_READ_REQUEST_CONTROL, 32'h0);
        chk("rrc reset", rd, 32'h00000000);
        chk("bytes reset", {19'h0, read_request_bytes}, {19'h0, BYTES_512});
        apb(1'b1, 12'h044, 32'hFFFFFFFF);
        apb(1'b0, 12'h044, 32'h0);
        chk("unmapped", rd, 32'h00000000);
        chk("no error", {31'h0, pslverr}, 32'h0);
        apb(1'b1, ADDR_CHIP_CONTROL_ZERO, 32'hFFFFFFFF);
        apb(1'b0, ADDR_CHIP_CONTROL_ZERO, 32'h0);
        chk("cc0 ones", rd, 32'h00FEF800);
        $display("test reset done");
    endtask : t_reset

    task t_bytes;
        full_prefetch <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, ADDR_CHIP_CONTROL_ZERO, 32'(k) << BIT_MRBC_LO);
            repeat (2) @(posedge pclk);
            case (k)
                1: exp_b = BYTES_128;
                2: exp_b = BYTES_256;
                4: exp_b = BYTES_1024;
                5: exp_b = BYTES_2048;
                6: exp_b = BYTES_4096;
                default: exp_b = BYTES_512;
            endcase
            chk("read bytes", {19'h0, read_request_bytes}, {19'h0, exp_b});
        end
        $display("test byte count done");
    endtask : t_bytes

    task t_pulses;
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, ADDR_CHIP_CONTROL_ZERO,
                (32'(m) << BIT_MALFORMED) | (32'(m) << BIT_FC_UPDATE));
            n_mal = 0;
            n_cu = 0;
            malformed_seen <= 1'b1;
            @(posedge pclk);
            malformed_seen <= 1'b0;
            repeat (4) begin
                credit_freed <= 1'b1;
                @(posedge pclk);
                credit_freed <= 1'b0;
                @(posedge pclk);
            end
            repeat (3) @(posedge pclk);
            chk("malformed", 32'(n_mal), 32'(m));
            chk("credit upd", 32'(n_cu), m ? 32'h4 : 32'h2);
        end
        $display("test pulses done");
    endtask : t_pulses

    task t_retry;
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        apb(1'b1, ADDR_CHIP_CONTROL_ZERO, 32'h1 << BIT_RETRY_LIM_LO);
        retries(255);
        apb(1'b0, ADDR_CHIP_CONTROL_ZERO, 32'h0);
        chk("retry early", {31'h0, rd[BIT_RETRY_STATUS]}, 32'h0);
        retries(1);
        apb(1'b0, ADDR_CHIP_CONTROL_ZERO, 32'h0);
        chk("retry set", {31'h0, rd[BIT_RETRY_STATUS]}, 32'h1);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b0, ADDR_INT_STATUS, 32'h0);
        chk("int status", rd, 32'h00000001);
        apb(1'b1, ADDR_INT_MASK, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        transaction_done <= 1'b1;
        apb(1'b1, ADDR_CHIP_CONTROL_ZERO, 32'h1 << BIT_RETRY_STATUS);
        transaction_done <= 1'b0;
        apb(1'b1, ADDR_INT_STATUS, 32'h1);
        apb(1'b0, ADDR_CHIP_CONTROL_ZERO, 32'h0);
        chk("retry clr", {31'h0, rd[BIT_RETRY_STATUS]}, 32'h0);
        retries(300);
        apb(1'b0, ADDR_CHIP_CONTROL_ZERO, 32'h0);
        chk("no limit", {31'h0, rd[BIT_RETRY_STATUS]}, 32'h0);
        $display("test retry done");
    endtask : t_retry

    task run_disc(input logic [31:0] cc0, input logic [31:0] rrc, input int lo, input int hi);
        apb(1'b1, ADDR_CHIP_CONTROL_ZERO, cc0);
        apb(1'b1, ADDR_READ_REQUEST_CONTROL, rrc);
        discard_start <= 1'b1;
        pci_clk_tick <= 1'b1;
        wait_hi(0, hi);
        discard_start <= 1'b0;
        pci_clk_tick <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("discard", {31'h0, c >= lo && c <= hi}, 32'h1);
    endtask : run_disc

    task t_discard;
        run_disc(32'h1 << BIT_SHORT_DUR, 32'h09000000, 63, 67);
        run_disc(32'h0, 32'h09000000, 1023, 1027);
        reverse_mode <= 1'b1;
        run_disc(32'h0, 32'h0A000000, 1023, 1027);
        run_disc(32'h00180000, 32'h0A000000, 300, 300);
        $display("test discard done");
    endtask : t_discard

    task t_cfg;
        apb(1'b1, ADDR_INT_MASK, 32'h2);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ADDR_CHIP_CONTROL_ZERO, 32'(k) << BIT_CRS_LO);
            cfg_retry_start <= 1'b1;
            wait_hi(1, 12600);
            chk("cfg timer", 32'(c >= (k ? 12498 : 623) && c <= (k ? 12503 : 628)), 32'h1);
            cfg_retry_start <= 1'b0;
            repeat (2) @(posedge pclk);
            chk("cfg irq", {31'h0, irq}, 32'h1);
            apb(1'b1, ADDR_INT_STATUS, 32'h2);
            chk("cfg irq clr", {31'h0, irq}, 32'h0);
        end
        apb(1'b1, ADDR_CHIP_CONTROL_ZERO, 32'h1 << BIT_DT_ORDER);
        chk("in order", {31'h0, in_order_only}, 32'h1);
        $display("test cfg and order done");
    endtask : t_cfg

    initial begin
        n_fail = 0;
        tests_run = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {reverse_mode, pci_clk_tick, malformed_seen, full_prefetch, credit_freed} = '0;
        {retry_seen, transaction_done, discard_start, cfg_retry_start} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_bytes();
        t_pulses();
        t_retry();
        t_discard();
        t_cfg();
        conclude();
    end
endmodule : bridge_chip_control_fields_test
